// ===== src/tid_pkg.sv
// package: register map, field positions and codes of the timer int/dma bank
package tid_pkg;
  // register page and offsets
  localparam logic [3:0] PAGE_DMA        = 4'h9;
  localparam logic [3:0] PAGE_MASK       = 4'hA;
  localparam logic [7:0] OFS_COUNTER_PTR = 8'hF0;
  localparam logic [7:0] OFS_ADDR_PTR    = 8'hF1;
  localparam logic [7:0] OFS_VECTOR      = 8'hF2;
  localparam logic [7:0] OFS_INT_DMA_CTL = 8'hF3;
  localparam logic [7:0] OFS_LOOPBACK    = 8'hF8;
  localparam logic [7:0] OFS_DMA_MASK    = 8'hFF;
  // reset values (pointers and vector have no defined reset, zero chosen)
  localparam logic [7:0] RST_COUNTER_PTR = 8'h00;
  localparam logic [7:0] RST_ADDR_PTR    = 8'h00;
  localparam logic [7:0] RST_VECTOR      = 8'h00;
  localparam logic [7:0] RST_INT_DMA_CTL = 8'hC7;
  localparam logic [7:0] RST_LOOPBACK    = 8'hFC;
  localparam logic [7:0] LOOPBACK_UNUSED = 8'hFC;
  // field positions
  localparam int BIT_AREA_SEL   = 0;
  localparam int BIT_MEM_EXT    = 0;
  localparam int BIT_DIR_IND    = 1;
  localparam int BIT_PTR2       = 2;
  localparam int BIT_CAP_EOB    = 7;
  localparam int BIT_CMP_EOB    = 6;
  localparam int BIT_CAP_SRC    = 5;
  localparam int BIT_CMP_DST    = 4;
  localparam int BIT_SWAP       = 3;
  localparam int BIT_LOOP_ODD   = 1;
  localparam int BIT_LOOP_EVEN  = 0;
  localparam int BIT_CAP_MASK   = 6;
  localparam int BIT_CMP_MASK   = 3;
  // vector group codes placed in bits 2:1
  localparam logic [1:0] GRP_OVF = 2'h0;
  localparam logic [1:0] GRP_CAP = 2'h2;
  localparam logic [1:0] GRP_CMP = 2'h3;
  // request group selected by the vector encoder, one-hot
  typedef enum logic [2:0] {
    GRP_SEL_NONE = 3'h0,
    GRP_SEL_OVF  = 3'h1,
    GRP_SEL_CAP  = 3'h2,
    GRP_SEL_CMP  = 3'h4
  } tid_grp_t;
endpackage

// ===== src/tid_vector_enc.sv
// vector encoder: picks the pending request group and forms the vector
`timescale 1ns/1ps
module tid_vector_enc
  import tid_pkg::*;
(
  // request groups from the timer
  input  wire logic       req_ovf,
  input  wire logic       req_cap,
  input  wire logic       req_cmp,
  // software upper vector bits
  input  wire logic [4:0] vector_upper,
  // result
  output logic            req_any,
  output logic [7:0]      vector_next
);
  wire tid_grp_t   grp;
  wire logic [1:0] grp_code;

  // compare wins over capture, capture over overflow
  assign grp = req_cmp ? GRP_SEL_CMP :
               req_cap ? GRP_SEL_CAP :
               req_ovf ? GRP_SEL_OVF : GRP_SEL_NONE;
  // code 01 is never produced
  assign grp_code = (grp == GRP_SEL_CMP) ? GRP_CMP :
                    (grp == GRP_SEL_CAP) ? GRP_CAP : GRP_OVF;
  assign req_any     = (grp != GRP_SEL_NONE);
  assign vector_next = {vector_upper, grp_code, 1'b0};
endmodule // tid_vector_enc

// ===== src/tid_loopback.sv
// on-chip output-to-input loopback for four timers
`timescale 1ns/1ps
module tid_loopback
  import tid_pkg::*;
(
  // control bits
  input  wire logic       loopback_odd,
  input  wire logic       loopback_even,
  // pins
  input  wire logic [3:0] timer_output_a,
  input  wire logic [3:0] pin_input_a,
  output logic [3:0]      timer_input_a
);
  wire logic [3:0] loop_sel;

  // timers 0 and 2 follow the even bit, 1 and 3 the odd bit
  assign loop_sel = {loopback_odd, loopback_even,
                     loopback_odd, loopback_even};
  // when off the input comes from its own pin only
  assign timer_input_a = (loop_sel & timer_output_a) |
                         (~loop_sel & pin_input_a);
endmodule // tid_loopback

// ===== src/tid_bank.sv
// interrupt vector, dma control and loopback register bank of a timer
//
// Function
// - counter pointer bit 0: 0 memory area, 1 register file; 1 masks ext select
// - address pointer bits 7:2 software written; bit 2 toggled in swap mode
// - register-file dma ignores address pointer except bit 2 in swap mode
// - address pointer bit 1 read-only: 0 capture source, 1 compare destination
// - memory area: bit 0 picks interrupt (0) or dma (1) segment register
// - one vector register; hardware supplies low three bits per group
// - vector bits 7:3 software written, upper part of 8-bit vector
// - bits 2:1 give group: 00 overflow, 10 capture, 11 compare
// - vector bit 0 always reads zero
// - capture eob flag bit 7 set at eob in swap, held 1 otherwise
// - compare eob flag bit 6 set at eob in swap, held 1 otherwise
// - bit 5 selects capture dma source: capture register or i/o port
// - bit 4 selects compare dma destination: compare register or i/o port
// - bit 3 enables swap mode for both channels together
// - bits 2:0 give shared priority level to the interrupt controller
// - loopback bit 1 ties output a to input a for timers 1 and 3
// - loopback bit 0 ties output a to input a for timers 0 and 2
// - compare swap mode toggles counter pointer bit 2 between two tables
// - dma mask bits set by software, cleared by hardware at end of block
`timescale 1ns/1ps
module tid_bank
  import tid_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // register file port
  input  wire logic [3:0] reg_page,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // events from the timer dma section
  input  wire logic       cap_eob,
  input  wire logic       cmp_eob,
  input  wire logic       dma_on_compare,
  // interrupt requests by group
  input  wire logic       req_ovf,
  input  wire logic       req_cap,
  input  wire logic       req_cmp,
  // to the interrupt and dma controller
  output logic [7:0]      irq_vector,
  output logic            irq_valid,
  output logic [2:0]      priority_level,
  output logic            dma_use_regfile,
  output logic            dma_use_dma_seg,
  output logic [7:0]      dma_address_ptr_out,
  output logic [7:0]      dma_counter_ptr_out,
  output logic            capture_transfer_source,
  output logic            compare_transfer_destination,
  output logic            swap_enable,
  output logic            capture0_dma_mask,
  output logic            compare0_dma_mask,
  // loopback pins
  input  wire logic [3:0] timer_output_a,
  input  wire logic [3:0] pin_input_a,
  output logic [3:0]      timer_input_a
);
  //////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] dma_counter_pointer;
  logic [7:0] dma_address_pointer;
  logic [4:0] vector_upper;
  logic [7:0] interrupt_dma_control;
  logic [1:0] pin_loopback_control;
  logic       dir_ind;

  //////////////////////////////////////////////////////////////////////////
  // address decode
  wire logic pg9     = (reg_page == PAGE_DMA);
  wire logic wr_cnt  = reg_wr & pg9 & (reg_addr == OFS_COUNTER_PTR);
  wire logic wr_adr  = reg_wr & pg9 & (reg_addr == OFS_ADDR_PTR);
  wire logic wr_vec  = reg_wr & pg9 & (reg_addr == OFS_VECTOR);
  wire logic wr_ctl  = reg_wr & pg9 & (reg_addr == OFS_INT_DMA_CTL);
  wire logic wr_loop = reg_wr & pg9 & (reg_addr == OFS_LOOPBACK);
  wire logic wr_mask = reg_wr & (reg_page == PAGE_MASK) &
                       (reg_addr == OFS_DMA_MASK);

  //////////////////////////////////////////////////////////////////////////
  // swap and eob terms
  wire logic swap    = interrupt_dma_control[BIT_SWAP];
  wire logic cmp_tog = swap & cmp_eob;
  // a write of 1 leaves the flag alone, so only zero clears it
  wire logic cap_clr = wr_ctl & ~reg_wdata[BIT_CAP_EOB];
  wire logic cmp_clr = wr_ctl & ~reg_wdata[BIT_CMP_EOB];
  wire logic [7:0] next_ctl_sw = wr_ctl ? reg_wdata : interrupt_dma_control;
  // force from the new swap bit so a flag never reads 0 with swap off;
  // a clear only counts while swap is already on
  wire logic next_swap = next_ctl_sw[BIT_SWAP];
  wire logic next_cap_flag = ~next_swap | cap_eob |
                             (interrupt_dma_control[BIT_CAP_EOB] &
                              ~(cap_clr & swap));
  wire logic next_cmp_flag = ~next_swap | cmp_eob |
                             (interrupt_dma_control[BIT_CMP_EOB] &
                              ~(cmp_clr & swap));

  //////////////////////////////////////////////////////////////////////////
  // pointer bit 2 toggle helper, used by both pointers
  function automatic logic [7:0] ptr_update(input logic [7:0] cur,
                                            input logic       wr,
                                            input logic [7:0] wd,
                                            input logic       tog);
    logic [7:0] v;
    v = wr ? wd : cur;
    v[BIT_PTR2] = v[BIT_PTR2] ^ tog;
    return v;
  endfunction

  wire logic [7:0] next_counter_ptr =
    ptr_update(dma_counter_pointer, wr_cnt, reg_wdata, cmp_tog);
  wire logic [7:0] next_address_ptr =
    ptr_update(dma_address_pointer, wr_adr, reg_wdata, cmp_tog);

  //////////////////////////////////////////////////////////////////////////
  // counter and address pointers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dma_counter_pointer <= RST_COUNTER_PTR;
      dma_address_pointer <= RST_ADDR_PTR;
    end else begin
      dma_counter_pointer <= next_counter_ptr;
      dma_address_pointer <= next_address_ptr;
    end
  end

  // direction indicator follows the channel being served, never software
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dir_ind <= 1'b0;
    end else begin
      dir_ind <= dma_on_compare;
    end
  end

  // vector upper bits, low bits belong to hardware
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vector_upper <= RST_VECTOR[7:3];
    end else if (wr_vec) begin
      vector_upper <= reg_wdata[7:3];
    end
  end

  // control register: eob flags with set over clear, rest software
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      interrupt_dma_control <= RST_INT_DMA_CTL;
    end else begin
      interrupt_dma_control <= {next_cap_flag, next_cmp_flag,
                                next_ctl_sw[5:0]};
    end
  end

  // loopback control, unused upper bits are not stored
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_loopback_control <= RST_LOOPBACK[1:0];
    end else if (wr_loop) begin
      pin_loopback_control <= reg_wdata[1:0];
    end
  end

  // dma masks: eob clears, beating a same-cycle software set
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      capture0_dma_mask <= 1'b0;
      compare0_dma_mask <= 1'b0;
    end else begin
      if (cap_eob) begin
        capture0_dma_mask <= 1'b0;
      end else if (wr_mask) begin
        capture0_dma_mask <= reg_wdata[BIT_CAP_MASK];
      end
      if (cmp_eob) begin
        compare0_dma_mask <= 1'b0;
      end else if (wr_mask) begin
        compare0_dma_mask <= reg_wdata[BIT_CMP_MASK];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux; the mask register only shows its two dma bits
  wire logic [7:0] rd_cnt = dma_counter_pointer;
  wire logic [7:0] rd_adr = {dma_address_pointer[7:2], dir_ind,
                             dma_address_pointer[BIT_MEM_EXT]};
  wire logic [7:0] rd_vec = {vector_upper, irq_vector[2:1], 1'b0};
  wire logic [7:0] rd_loop = LOOPBACK_UNUSED |
                             {6'h00, pin_loopback_control};
  wire logic [7:0] rd_mask = {1'b0, capture0_dma_mask, 2'h0,
                              compare0_dma_mask, 3'h0};
  wire logic [7:0] next_rdata =
    !reg_rd ? reg_rdata :
    (pg9 && reg_addr == OFS_COUNTER_PTR) ? rd_cnt :
    (pg9 && reg_addr == OFS_ADDR_PTR)    ? rd_adr :
    (pg9 && reg_addr == OFS_VECTOR)      ? rd_vec :
    (pg9 && reg_addr == OFS_INT_DMA_CTL) ? interrupt_dma_control :
    (pg9 && reg_addr == OFS_LOOPBACK)    ? rd_loop :
    ((reg_page == PAGE_MASK) && reg_addr == OFS_DMA_MASK) ? rd_mask :
    8'h00;

  // read data held until the next read
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // vector to the interrupt controller
  logic       req_any;
  logic [7:0] vector_next;

  tid_vector_enc u_vec (
    .req_ovf      (req_ovf),
    .req_cap      (req_cap),
    .req_cmp      (req_cmp),
    .vector_upper (vector_upper),
    .req_any      (req_any),
    .vector_next  (vector_next)
  );

  // the group code is kept from the last request for software to read
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_vector <= RST_VECTOR;
      irq_valid  <= 1'b0;
    end else begin
      irq_vector <= req_any ? vector_next :
                    {vector_upper, irq_vector[2:0]};
      irq_valid  <= req_any;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // static dma and priority outputs
  assign priority_level      = interrupt_dma_control[2:0];
  assign swap_enable         = swap;
  assign capture_transfer_source =
    interrupt_dma_control[BIT_CAP_SRC];
  assign compare_transfer_destination =
    interrupt_dma_control[BIT_CMP_DST];
  assign dma_use_regfile     = dma_counter_pointer[BIT_AREA_SEL];
  // extension select only counts in the memory area
  assign dma_use_dma_seg     = ~dma_counter_pointer[BIT_AREA_SEL] &
                               dma_address_pointer[BIT_MEM_EXT];
  // register-file dma sees only the table bit of the address pointer
  assign dma_address_ptr_out =
    dma_counter_pointer[BIT_AREA_SEL] ?
      {5'h00, swap & dma_address_pointer[BIT_PTR2], 2'h0} :
      rd_adr;
  assign dma_counter_ptr_out = dma_counter_pointer;

  tid_loopback u_loop (
    .loopback_odd   (pin_loopback_control[BIT_LOOP_ODD]),
    .loopback_even  (pin_loopback_control[BIT_LOOP_EVEN]),
    .timer_output_a (timer_output_a),
    .pin_input_a    (pin_input_a),
    .timer_input_a  (timer_input_a)
  );

  //////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_cmp_eob_swap;
    swap && cmp_eob && !wr_adr;
  endsequence

  property p_ptr_toggle;
    @(posedge core_clk) disable iff (!resetn)
    s_cmp_eob_swap |=> dma_address_pointer[BIT_PTR2] !=
                       $past(dma_address_pointer[BIT_PTR2]);
  endproperty
  a_ptr_toggle: assert property (p_ptr_toggle)
    else $error("address pointer bit 2 not toggled");

  property p_cnt_toggle;
    @(posedge core_clk) disable iff (!resetn)
    (swap && cmp_eob && !wr_cnt) |=> dma_counter_pointer[BIT_PTR2] !=
                                     $past(dma_counter_pointer[BIT_PTR2]);
  endproperty
  a_cnt_toggle: assert property (p_cnt_toggle)
    else $error("counter pointer bit 2 not toggled");

  property p_cap_held;
    @(posedge core_clk) disable iff (!resetn)
    !swap |=> interrupt_dma_control[BIT_CAP_EOB];
  endproperty
  a_cap_held: assert property (p_cap_held)
    else $error("capture eob flag not held while swap off");

  property p_cmp_set;
    @(posedge core_clk) disable iff (!resetn)
    (cmp_eob || !swap) |=> interrupt_dma_control[BIT_CMP_EOB];
  endproperty
  a_cmp_set: assert property (p_cmp_set)
    else $error("compare eob flag not set");

  property p_eob_clear;
    @(posedge core_clk) disable iff (!resetn)
    (swap && cap_clr && !cap_eob && reg_wdata[BIT_SWAP]) |=>
      !interrupt_dma_control[BIT_CAP_EOB];
  endproperty
  a_eob_clear: assert property (p_eob_clear)
    else $error("capture eob flag not cleared by write of zero");

  property p_eob_forced;
    @(posedge core_clk) disable iff (!resetn)
    !swap |-> interrupt_dma_control[BIT_CAP_EOB] &&
              interrupt_dma_control[BIT_CMP_EOB];
  endproperty
  a_eob_forced: assert property (p_eob_forced)
    else $error("eob flag low while swap off");

  property p_vec_bit0;
    @(posedge core_clk) disable iff (!resetn)
    irq_vector[0] == 1'b0 && irq_vector[2:1] != 2'h1;
  endproperty
  a_vec_bit0: assert property (p_vec_bit0)
    else $error("vector low bits illegal");

  property p_vec_group;
    @(posedge core_clk) disable iff (!resetn)
    (req_cmp |=> irq_vector[2:1] == GRP_CMP) and
    ((req_cap && !req_cmp) |=> irq_vector[2:1] == GRP_CAP);
  endproperty
  a_vec_group: assert property (p_vec_group)
    else $error("vector group code wrong");

  property p_mask_clr;
    @(posedge core_clk) disable iff (!resetn)
    cap_eob |=> !capture0_dma_mask ##1 (!capture0_dma_mask || $past(wr_mask));
  endproperty
  a_mask_clr: assert property (p_mask_clr)
    else $error("capture dma mask not cleared at end of block");

  property p_seg_sel;
    @(posedge core_clk) disable iff (!resetn)
    dma_use_regfile |-> !dma_use_dma_seg;
  endproperty
  a_seg_sel: assert property (p_seg_sel)
    else $error("segment select active in register file area");

  property p_loop;
    @(posedge core_clk) disable iff (!resetn)
    pin_loopback_control[BIT_LOOP_EVEN] |->
      timer_input_a[0] == timer_output_a[0] &&
      timer_input_a[2] == timer_output_a[2];
  endproperty
  a_loop: assert property (p_loop)
    else $error("even loopback not connected");
endmodule // tid_bank

// ===== verif/tid_ctrl_model.sv
// far-side model: interrupt and dma controller running timer dma blocks
`timescale 1ns/1ps
module tid_ctrl_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // block start commands from the bench
  input  wire logic go_cap,
  input  wire logic go_cmp,
  input  wire logic slow,
  // dma masks from the timer
  input  wire logic capture0_dma_mask,
  input  wire logic compare0_dma_mask,
  // events back to the timer
  output logic      cap_eob,
  output logic      cmp_eob,
  output logic      dma_on_compare
);
  int   left;
  logic on_cmp;
  ////////////////////////////////////////
  // a block starts only while its mask enables it, eob closes it
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      left <= 0;
      on_cmp <= 1'b0;
      cap_eob <= 1'b0;
      cmp_eob <= 1'b0;
    end else begin
      cap_eob <= 1'b0;
      cmp_eob <= 1'b0;
      if (left == 1) begin
        cap_eob <= !on_cmp;
        cmp_eob <= on_cmp;
        left <= 0;
      end else if (left > 1) begin
        left <= left - 1;
      end else if (go_cmp && compare0_dma_mask) begin
        on_cmp <= 1'b1;
        left <= slow ? 8 : 1;
      end else if (go_cap && capture0_dma_mask) begin
        on_cmp <= 1'b0;
        left <= slow ? 8 : 1;
      end
    end
  end
  // level tells which channel is served, low between blocks
  assign dma_on_compare = on_cmp && (left != 0);
endmodule // tid_ctrl_model

// ===== verif/tb_timer_interrupt_dma_control.sv
// self-checking bench of the timer vector, dma control and loopback bank
`timescale 1ns/1ps
module tb_timer_interrupt_dma_control;
  import tid_pkg::*;
  logic       core_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [3:0] reg_page = 4'h0;
  logic [7:0] reg_addr = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic       req_ovf = 1'b0, req_cap = 1'b0, req_cmp = 1'b0;
  logic [3:0] timer_output_a = 4'h0, pin_input_a = 4'h0;
  logic       go_cap = 1'b0, go_cmp = 1'b0, slow = 1'b0;
  wire  [7:0] reg_rdata, irq_vector, ptr_out, cnt_out;
  wire  [2:0] priority_level;
  wire  [3:0] timer_input_a;
  wire        irq_valid, use_rf, use_seg, src, dst, swap, cap_m, cmp_m;
  wire        cap_eob, cmp_eob, on_cmp;
  int         fails = 0;
  int         n_tests = 0;
  logic [7:0] v, c, p, d;
  ////////////////////////////////////////
  always #50 core_clk = ~core_clk;
  tid_bank dut (.core_clk(core_clk), .resetn(resetn), .reg_page(reg_page),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cap_eob(cap_eob),
    .cmp_eob(cmp_eob), .dma_on_compare(on_cmp), .req_ovf(req_ovf),
    .req_cap(req_cap), .req_cmp(req_cmp), .irq_vector(irq_vector),
    .irq_valid(irq_valid), .priority_level(priority_level),
    .dma_use_regfile(use_rf), .dma_use_dma_seg(use_seg),
    .dma_address_ptr_out(ptr_out), .dma_counter_ptr_out(cnt_out),
    .capture_transfer_source(src), .compare_transfer_destination(dst),
    .swap_enable(swap), .capture0_dma_mask(cap_m),
    .compare0_dma_mask(cmp_m), .timer_output_a(timer_output_a),
    .pin_input_a(pin_input_a), .timer_input_a(timer_input_a));
  tid_ctrl_model u_ctrl (.core_clk(core_clk), .resetn(resetn),
    .go_cap(go_cap), .go_cmp(go_cmp), .slow(slow),
    .capture0_dma_mask(cap_m), .compare0_dma_mask(cmp_m),
    .cap_eob(cap_eob), .cmp_eob(cmp_eob), .dma_on_compare(on_cmp));
  ////////////////////////////////////////
  // expected vector: software upper bits, group code, bit 0 low
  function automatic logic [7:0] vec_exp(logic [7:0] up, int g);
    return {up[7:3], (g == 0) ? GRP_OVF : (g == 1) ? GRP_CAP : GRP_CMP, 1'b0};
  endfunction
  // even timers follow select bit 0, odd timers bit 1
  function automatic logic [3:0] loop_exp(int l, logic [3:0] o, logic [3:0] q);
    logic [3:0] r;
    for (int i = 0; i < 4; i++) r[i] = l[i % 2] ? o[i] : q[i];
    return r;
  endfunction
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] pg, logic [7:0] a, logic [7:0] w);
    @(posedge core_clk);
    reg_page <= pg;
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // masked read; the data is registered on the edge that takes the strobe
  task automatic rdchk(string what, logic [3:0] pg, logic [7:0] a,
                       logic [7:0] exp, logic [7:0] m = 8'hFF);
    @(posedge core_clk);
    reg_page <= pg;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(what, reg_rdata & m, exp);
  endtask
  // start one block and wait, bounded, until its mask is dropped
  task automatic run_blk(logic cmp, logic s);
    @(posedge core_clk);
    go_cmp <= cmp;
    go_cap <= !cmp;
    slow <= s;
    @(posedge core_clk);
    go_cmp <= 1'b0;
    go_cap <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 if (s) chk("dir", 8'(ptr_out[1]), 8'h01);
    for (int k = 0; k < 40 && (cmp ? cmp_m : cap_m); k++) @(posedge core_clk);
    #1 chk("blk_end", 8'(cmp ? cmp_m : cap_m), 8'h00);
  endtask
  task automatic complete_run();
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////
  // watchdog well above the hundred-odd cycles the sequence needs
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    complete_run();
  end
  initial begin
    void'($urandom(69));
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    rdchk("ctl_rst", PAGE_DMA, OFS_INT_DMA_CTL, 8'hC7);
    rdchk("loop_rst", PAGE_DMA, OFS_LOOPBACK, 8'hFC);
    rdchk("mask_rst", PAGE_MASK, OFS_DMA_MASK, 8'h00);
    // vector: upper bits kept, low bits from the requesting group
    v = 8'($urandom);
    wr(PAGE_DMA, OFS_VECTOR, v);
    rdchk("vec", PAGE_DMA, OFS_VECTOR, {v[7:3], 3'b000}, 8'hF9);
    for (int g = 0; g < 4; g++) begin
      @(posedge core_clk);
      {req_cmp, req_cap, req_ovf} <= (g == 3) ? 3'b111 : 3'(1 << g);
      @(posedge core_clk);
      #1 chk("irq_valid", 8'(irq_valid), 8'h01);
      chk("irq_vector", irq_vector, vec_exp(v, g));
    end
    @(posedge core_clk);
    {req_cmp, req_cap, req_ovf} <= 3'b000;
    rdchk("vec_b0", PAGE_DMA, OFS_VECTOR, 8'h00, 8'h01);
    chk("irq_idle", 8'(irq_valid), 8'h00);
    chk("vec_kept", irq_vector, vec_exp(v, 2));
    // control bits with swap off, flags must stay set
    for (int i = 0; i < 4; i++) begin
      c = 8'($urandom) & 8'h37;
      wr(PAGE_DMA, OFS_INT_DMA_CTL, c);
      chk("prio", 8'(priority_level), 8'(c[2:0]));
      chk("src", 8'(src), 8'(c[5]));
      chk("dst", 8'(dst), 8'(c[4]));
      rdchk("ctl", PAGE_DMA, OFS_INT_DMA_CTL, c | 8'hC0);
    end
    // swap on, then a second zero write clears both flags
    wr(PAGE_DMA, OFS_INT_DMA_CTL, 8'h0B);
    chk("swap", 8'(swap), 8'h01);
    wr(PAGE_DMA, OFS_INT_DMA_CTL, 8'h0B);
    rdchk("ctl_clr", PAGE_DMA, OFS_INT_DMA_CTL, 8'h0B);
    wr(PAGE_DMA, OFS_COUNTER_PTR, 8'h00);
    p = 8'($urandom) | 8'h02;
    wr(PAGE_DMA, OFS_ADDR_PTR, p);
    rdchk("aptr", PAGE_DMA, OFS_ADDR_PTR, p & 8'hFD);
    chk("seg", 8'(use_seg), 8'(p[0]));
    chk("regfile", 8'(use_rf), 8'h00);
    wr(PAGE_MASK, OFS_DMA_MASK, 8'h48);
    rdchk("mask", PAGE_MASK, OFS_DMA_MASK, 8'h48);
    // slow compare block: eob flag, mask drop, pointer bit 2 toggles
    run_blk(1'b1, 1'b1);
    rdchk("ctl_cme", PAGE_DMA, OFS_INT_DMA_CTL, 8'h4B);
    rdchk("mask_cm", PAGE_MASK, OFS_DMA_MASK, 8'h40);
    rdchk("aptr_tg", PAGE_DMA, OFS_ADDR_PTR, (p ^ 8'h04) & 8'hFD);
    rdchk("cptr_tg", PAGE_DMA, OFS_COUNTER_PTR, 8'h04);
    chk("cnt_out", cnt_out, 8'h04);
    // prompt capture block
    run_blk(1'b0, 1'b0);
    rdchk("ctl_cpe", PAGE_DMA, OFS_INT_DMA_CTL, 8'hCB);
    rdchk("mask_cp", PAGE_MASK, OFS_DMA_MASK, 8'h00);
    // register-file area: only the table bit of the pointer matters
    wr(PAGE_DMA, OFS_COUNTER_PTR, 8'h05);
    chk("regfile", 8'(use_rf), 8'h01);
    chk("seg_rf", 8'(use_seg), 8'h00);
    chk("ptr_rf", ptr_out, {5'h00, ~p[2], 2'b00});
    wr(PAGE_DMA, OFS_INT_DMA_CTL, 8'h03);
    rdchk("ctl_off", PAGE_DMA, OFS_INT_DMA_CTL, 8'hC3);
    // loopback: every select setting with random pins
    for (int l = 0; l < 4; l++) begin
      wr(PAGE_DMA, OFS_LOOPBACK, 8'(l) | (8'($urandom) & 8'hFC));
      rdchk("loop", PAGE_DMA, OFS_LOOPBACK, 8'hFC | 8'(l));
      @(posedge core_clk);
      timer_output_a <= 4'($urandom);
      pin_input_a <= 4'($urandom);
      @(posedge core_clk);
      #1 chk("tin", 8'(timer_input_a),
             8'(loop_exp(l, timer_output_a, pin_input_a)));
    end
    complete_run();
  end
endmodule // tb_timer_interrupt_dma_control
